// *** reset_seq_pkg.sv ***
// Shared constants for the reset sequencer and prescaler.
package reset_seq_pkg;
	// ----------------------------------------
	// Timing counts in reference clock cycles
	// ----------------------------------------
	localparam int PIN_DRIVE_CYCLES = 32;
	localparam int INTERNAL_RESET_TAIL_CYCLES = 32;
	localparam int OSC_STABLE_CYCLES = 4096;
	localparam int POR_RELEASE_CYCLES = 64;
	localparam int PIN_FILTER_CYCLES = 67;
	localparam int SHORT_RECOVERY_CYCLES = 32;
	localparam int LONG_RECOVERY_CYCLES = 4096;
	// Period of the reference clock in ns.
	localparam int CLOCK_PERIOD_NS = 10;
	// ----------------------------------------
	// Prescaler layout
	// ----------------------------------------
	localparam int PRESCALER_WIDTH = 13;
	localparam int SERVICE_CLEAR_LOW = 4;
	localparam int SERVICE_CLEAR_HIGH = 12;
	localparam int WATCHDOG_WIDTH = 8;
	// ----------------------------------------
	// Cause register field positions
	// ----------------------------------------
	localparam int CAUSE_POWER_ON = 7;
	localparam int CAUSE_PIN = 6;
	localparam int CAUSE_WATCHDOG = 5;
	localparam int CAUSE_ILLEGAL_OPCODE = 4;
	localparam int CAUSE_ILLEGAL_ADDRESS = 3;
	localparam int CAUSE_LOW_VOLTAGE = 1;
	localparam logic [7:0] CAUSE_RESET_VALUE = 8'h80;
	// Interrupt source count.
	localparam int IRQ_SOURCES = 8;
	// Sequencer states.
	typedef enum logic [2:0] {
		SEQ_RUN,
		SEQ_STABILISE,
		SEQ_PIN_DRIVE,
		SEQ_TAIL,
		SEQ_STOPPED,
		SEQ_RECOVER
	} seq_state_t;
endpackage

// *** level_sync.sv ***
// Two-flip-flop level synchroniser.
`timescale 1ns/1ns
module level_sync #(
	parameter logic RESET_VALUE = 1'b0
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic clockEnable,
	input wire logic asyncIn,
	output logic syncOut
);
	// State of the synchroniser.
	typedef struct packed {
		logic first;
		logic second;
	} sync_t;
	sync_t state;
	sync_t next_state;

	// Shift the input through two stages; only the second stage is read.
	always_comb begin
		next_state = state;
		if (clockEnable) begin
			next_state.first = asyncIn;
			next_state.second = state.first;
		end
	end

	// Register the stages.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			state <= '{first: RESET_VALUE, second: RESET_VALUE};
		end else begin
			state <= next_state;
		end
	end

	assign syncOut = state.second;
endmodule

// *** irq_latch.sv ***
// Latches pending interrupts and arbitrates them at processing start.
`timescale 1ns/1ns
module irq_latch #(
	parameter int SOURCES = reset_seq_pkg::IRQ_SOURCES
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic clockEnable,
	input wire logic [SOURCES-1:0] irqRequest,
	input wire logic irqStart,
	input wire logic irqDone,
	output logic irqActive,
	output logic [$clog2(SOURCES)-1:0] vectorSelect
);
	// State of the latch.
	typedef struct packed {
		logic active;
		logic [$clog2(SOURCES)-1:0] vector;
	} latch_t;
	latch_t state;
	latch_t next_state;
	logic [$clog2(SOURCES)-1:0] winner;
	logic anyRequest;

	// Lowest index wins arbitration.
	always_comb begin
		winner = '0;
		anyRequest = 1'b0;
		for (int i = SOURCES - 1; i >= 0; i--) begin
			if (irqRequest[i]) begin
				winner = i[$clog2(SOURCES)-1:0];
				anyRequest = 1'b1;
			end
		end
	end

	// Hold the latched choice until it is serviced.
	always_comb begin
		next_state = state;
		if (clockEnable) begin
			if (state.active && irqDone) begin
				next_state.active = 1'b0;
			end else if (!state.active && irqStart && anyRequest) begin
				next_state.active = 1'b1;
				next_state.vector = winner;
			end
		end
	end

	// Register the latch.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign irqActive = state.active;
	assign vectorSelect = state.vector;
endmodule

// *** reset_sequencer_and_prescaler.sv ***
// Reset sequencer, cause flags, prescaler, watchdog and interrupt latch.
`timescale 1ns/1ns
// How it works
// - Internal resets drive pin low 32 cycles.
// - Internal reset holds 32 more cycles.
// - Power-on and low-voltage count 4096 first.
// - Power-up: 4096 pin low, release 64 later.
// - Power-on sets its flag, clears others.
// - Main clock on, bus clocks off 4096.
// - Watchdog overflow resets, sets its flag.
// - Service write clears watchdog, prescaler 12:4.
// - Thirteen-bit prescaler overflow clocks the watchdog.
// - Watchdog reset synchronised before use.
// - Watchdog disabled only by high-voltage qualifier.
// - Illegal instruction sets flag and resets.
// - Stop disabled makes stop illegal opcode.
// - Unmapped opcode fetch resets; data does not.
// - Low voltage: flag, 4096 pin low, 64.
// - Stop clears prescaler; recovery 32 or 4096.
// - External pin reset leaves prescaler alone.
// - Prescaler free-runs after reset states.
// - After power-on, enable bus clock machine.
// - Interrupt entry stacks, return restores.
// - Latch interrupts, no pre-emption after latch.
// - Pin flag needs 67 low cycles.
// - Every source but the pin resets and sets own flag; the pin only sets its flag.
module reset_sequencer_and_prescaler #(
	parameter int STABILISE_CYCLES = reset_seq_pkg::OSC_STABLE_CYCLES,
	parameter int LONG_RECOVERY = reset_seq_pkg::LONG_RECOVERY_CYCLES,
	parameter int WATCHDOG_BITS = reset_seq_pkg::WATCHDOG_WIDTH
) (
	// Prescaler and sequencer run on this edge, standing for the
	// falling edge of the crystal reference clock.
	input wire logic clock,
	input wire logic rst_b,
	input wire logic clockEnable,
	// One-cycle pulse from the power-on detector.
	input wire logic power_on_pulse,
	// Low-voltage detector output, asynchronous level.
	input wire logic lowVoltage,
	// Reset pin: sensed level, drive low data and enable.
	input wire logic resetPinIn,
	output logic resetPinOut,
	output logic resetPinOe,
	// Processor events, same clock domain.
	input wire logic illegalDecode,
	input wire logic stopInstruction,
	input wire logic opcodeFetch,
	input wire logic unmappedAddress,
	input wire logic serviceWrite,
	input wire logic wakeEvent,
	// Option bits.
	input wire logic stopEnable,
	input wire logic short_stop_recovery,
	// High-voltage qualifiers for watchdog disable.
	input wire logic monitorMode,
	input wire logic breakState,
	input wire logic highVoltageResetPin,
	input wire logic highVoltageIrqPin,
	// Interrupt side.
	input wire logic [reset_seq_pkg::IRQ_SOURCES-1:0] irqRequest,
	input wire logic irqStart,
	input wire logic return_from_interrupt,
	output logic irqActive,
	output logic [$clog2(reset_seq_pkg::IRQ_SOURCES)-1:0] vectorSelect,
	output logic stackPush,
	output logic stackRestore,
	// Reset and clock outputs.
	output logic internal_reset,
	output logic gen_main_clock_out,
	output logic internal_bus_clocks,
	output logic busClockEnable,
	output logic [7:0] reset_cause_register,
	output logic [reset_seq_pkg::PRESCALER_WIDTH-1:0] prescaler
);
	// ----------------------------------------
	// Types and state
	// ----------------------------------------
	localparam int PW = reset_seq_pkg::PRESCALER_WIDTH;
	localparam int CW = 13;
	// Cycle counts as counter-width constants.
	localparam logic [CW-1:0] PIN_LAST = CW'(reset_seq_pkg::PIN_DRIVE_CYCLES - 1);
	localparam logic [CW-1:0] TAIL_LAST = CW'(reset_seq_pkg::INTERNAL_RESET_TAIL_CYCLES - 1);
	localparam logic [CW-1:0] STAB_LAST = CW'(STABILISE_CYCLES - 1);
	localparam logic [CW-1:0] SHORT_LAST = CW'(reset_seq_pkg::SHORT_RECOVERY_CYCLES - 1);
	localparam logic [CW-1:0] LONG_LAST = CW'(LONG_RECOVERY - 1);
	localparam logic [6:0] FILTER_LAST = 7'(reset_seq_pkg::PIN_FILTER_CYCLES - 1);

	// Whole state of the sequencer.
	typedef struct packed {
		reset_seq_pkg::seq_state_t seq;
		logic [CW-1:0] count;
		logic [PW-1:0] prescale;
		logic [WATCHDOG_BITS-1:0] watchdog;
		logic [7:0] cause;
		logic [6:0] pinLowCount;
		logic pinFlagDone;
		logic longSeq;
		logic recoverShort;
		logic busEnable;
		logic irqWasActive;
	} seq_t;
	seq_t state;
	seq_t next_state;

	// Synchronised inputs.
	logic pinLowSync;
	logic lowVoltageSync;
	logic watchdogResetSync;
	// Raw watchdog overflow level before synchronising.
	logic watchdogOverflowRaw;
	logic watchdogDisable;
	logic illegalOpcode;
	logic illegalAddress;
	logic prescaleOverflow;
	logic lowVoltagePrev;

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	// pin sync
	level_sync #(.RESET_VALUE(1'b0)) pinSync (
		.clock(clock),
		.rst_b(rst_b),
		.clockEnable(clockEnable),
		.asyncIn(~resetPinIn),
		.syncOut(pinLowSync)
	);

	// Low-voltage level is asynchronous.
	level_sync #(.RESET_VALUE(1'b0)) lvSync (
		.clock(clock),
		.rst_b(rst_b),
		.clockEnable(clockEnable),
		.asyncIn(lowVoltage),
		.syncOut(lowVoltageSync)
	);

	level_sync #(.RESET_VALUE(1'b0)) wdSync (
		.clock(clock),
		.rst_b(rst_b),
		.clockEnable(clockEnable),
		.asyncIn(watchdogOverflowRaw),
		.syncOut(watchdogResetSync)
	);

	// Interrupt latch and arbiter.
	irq_latch #(.SOURCES(reset_seq_pkg::IRQ_SOURCES)) irqUnit (
		.clock(clock),
		.rst_b(rst_b),
		.clockEnable(clockEnable),
		.irqRequest(irqRequest),
		.irqStart(irqStart & ~internal_reset),
		.irqDone(return_from_interrupt),
		.irqActive(irqActive),
		.vectorSelect(vectorSelect)
	);

	// ----------------------------------------
	// Event decode
	// ----------------------------------------
	// Decode illegal events and the watchdog qualifier.
	always_comb begin
		watchdogDisable = (monitorMode & (highVoltageResetPin | highVoltageIrqPin))
			| (breakState & highVoltageResetPin);
		illegalOpcode = illegalDecode | (stopInstruction & ~stopEnable);
		illegalAddress = opcodeFetch & unmappedAddress;
		prescaleOverflow = &state.prescale;
		watchdogOverflowRaw = (&state.watchdog) & prescaleOverflow & ~watchdogDisable;
	end

	// Edge memory for the low-voltage level.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			lowVoltagePrev <= 1'b0;
		end else if (clockEnable) begin
			lowVoltagePrev <= lowVoltageSync;
		end
	end

	// ----------------------------------------
	// Sequencer next state
	// ----------------------------------------
	// Computes counters, flags and the reset sequence.
	always_comb begin
		next_state = state;
		if (clockEnable) begin
			next_state.prescale = state.prescale + PW'(1);
			if (prescaleOverflow) begin
				next_state.watchdog = state.watchdog + WATCHDOG_BITS'(1);
			end
			if (serviceWrite) begin
				next_state.watchdog = '0;
				next_state.prescale[reset_seq_pkg::SERVICE_CLEAR_HIGH:
					reset_seq_pkg::SERVICE_CLEAR_LOW] = '0;
			end
			// Interrupt entry stacking follows a fresh latch.
			next_state.irqWasActive = irqActive;
			// pin reset does not touch prescaler
			if (pinLowSync && state.seq == reset_seq_pkg::SEQ_RUN) begin
				if (state.pinLowCount != FILTER_LAST) begin
					next_state.pinLowCount = state.pinLowCount + 7'(1);
				end else if (!state.pinFlagDone) begin
					next_state.pinFlagDone = 1'b1;
					next_state.cause = 8'h00;
					next_state.cause[reset_seq_pkg::CAUSE_PIN] = 1'b1;
				end
			end else if (!pinLowSync) begin
				next_state.pinLowCount = '0;
				next_state.pinFlagDone = 1'b0;
			end

			case (state.seq)
				reset_seq_pkg::SEQ_RUN: begin
					next_state.count = '0;
					if (lowVoltageSync && !lowVoltagePrev) begin
						next_state.cause = 8'h00;
						next_state.cause[reset_seq_pkg::CAUSE_LOW_VOLTAGE] = 1'b1;
						next_state.seq = reset_seq_pkg::SEQ_STABILISE;
						next_state.prescale = '0;
						// Like every internal reset, this one restarts the watchdog.
						next_state.watchdog = '0;
						next_state.busEnable = 1'b0;
					end else if (watchdogResetSync || illegalOpcode || illegalAddress) begin
						next_state.cause = 8'h00;
						next_state.cause[reset_seq_pkg::CAUSE_WATCHDOG] = watchdogResetSync;
						next_state.cause[reset_seq_pkg::CAUSE_ILLEGAL_OPCODE] = illegalOpcode;
						next_state.cause[reset_seq_pkg::CAUSE_ILLEGAL_ADDRESS] = illegalAddress;
						next_state.seq = reset_seq_pkg::SEQ_PIN_DRIVE;
						next_state.prescale = '0;
						next_state.watchdog = '0;
					end else if (stopInstruction && stopEnable) begin
						next_state.seq = reset_seq_pkg::SEQ_STOPPED;
						next_state.prescale = '0;
					end
				end
				reset_seq_pkg::SEQ_STABILISE: begin
					next_state.count = state.count + CW'(1);
					if (state.count == STAB_LAST) begin
						next_state.count = '0;
						next_state.seq = reset_seq_pkg::SEQ_PIN_DRIVE;
					end
				end
				reset_seq_pkg::SEQ_PIN_DRIVE: begin
					next_state.count = state.count + CW'(1);
					if (state.count == PIN_LAST) begin
						next_state.count = '0;
						next_state.seq = reset_seq_pkg::SEQ_TAIL;
					end
				end
				reset_seq_pkg::SEQ_TAIL: begin
					// 64 total after the long count
					next_state.count = state.count + CW'(1);
					if (state.count == TAIL_LAST) begin
						next_state.count = '0;
						next_state.seq = reset_seq_pkg::SEQ_RUN;
						next_state.busEnable = 1'b1;
					end
				end
				reset_seq_pkg::SEQ_STOPPED: begin
					// Prescaler held in reset until recovery begins.
					next_state.prescale = '0;
					if (wakeEvent) begin
						next_state.recoverShort = short_stop_recovery;
						next_state.seq = reset_seq_pkg::SEQ_RECOVER;
					end
				end
				reset_seq_pkg::SEQ_RECOVER: begin
					next_state.count = state.count + CW'(1);
					if (state.count == (state.recoverShort ? SHORT_LAST : LONG_LAST)) begin
						next_state.count = '0;
						next_state.seq = reset_seq_pkg::SEQ_RUN;
					end
				end
				default: begin
					next_state.seq = reset_seq_pkg::SEQ_RUN;
				end
			endcase
			next_state.longSeq = (next_state.seq == reset_seq_pkg::SEQ_STABILISE);
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	// Reset or a power-on pulse starts the power-on sequence.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			state <= '{seq: reset_seq_pkg::SEQ_STABILISE, count: '0, prescale: '0,
				watchdog: '0, cause: reset_seq_pkg::CAUSE_RESET_VALUE, pinLowCount: '0,
				pinFlagDone: 1'b0, longSeq: 1'b1, recoverShort: 1'b0, busEnable: 1'b0,
				irqWasActive: 1'b0};
		end else if (clockEnable && power_on_pulse) begin
			state <= '{seq: reset_seq_pkg::SEQ_STABILISE, count: '0, prescale: '0,
				watchdog: '0, cause: reset_seq_pkg::CAUSE_RESET_VALUE, pinLowCount: '0,
				pinFlagDone: 1'b0, longSeq: 1'b1, recoverShort: 1'b0, busEnable: 1'b0,
				irqWasActive: 1'b0};
		end else begin
			state <= next_state;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Drive pin and clock controls from the sequencer state.
	always_comb begin
		resetPinOe = (state.seq == reset_seq_pkg::SEQ_STABILISE)
			|| (state.seq == reset_seq_pkg::SEQ_PIN_DRIVE);
		resetPinOut = 1'b0;
		internal_reset = resetPinOe || (state.seq == reset_seq_pkg::SEQ_TAIL);
		// main clock runs except when stopped or recovering
		gen_main_clock_out = (state.seq != reset_seq_pkg::SEQ_STOPPED)
			&& (state.seq != reset_seq_pkg::SEQ_RECOVER);
		internal_bus_clocks = (state.seq == reset_seq_pkg::SEQ_RUN);
		busClockEnable = state.busEnable;
		reset_cause_register = state.cause;
		prescaler = state.prescale;
		// stack on entry, restore on return
		stackPush = irqActive && !state.irqWasActive;
		stackRestore = return_from_interrupt && irqActive;
	end
endmodule

// *** reset_pin_partner.sv ***
// Peripheral chip that shares the pulled-up reset line with the device.
`timescale 1ns/1ns
module reset_pin_partner (
	input wire logic clock,
	input wire logic resetPinOut,
	input wire logic resetPinOe,
	input wire logic holdLow,
	output logic pinLevel,
	output logic [15:0] lastLow
);
	// Length of the low span in progress.
	logic [15:0] lowRun = 16'h0000;
	// The line is pulled up unless either party drives it low.
	assign pinLevel = !((resetPinOe && !resetPinOut) || holdLow);
	// Record each finished low span so the bench can see how long we were reset.
	always @(posedge clock) begin
		if (!pinLevel) begin
			lowRun <= lowRun + 16'h0001;
		end else if (lowRun != 16'h0000) begin
			lastLow <= lowRun;
			lowRun <= 16'h0000;
		end
	end
endmodule

// *** reset_seq_sva.sv ***
// Port checker for the reset sequencer and prescaler.
`timescale 1ns/1ns
module reset_seq_sva #(
	parameter int STABILISE_CYCLES = 16
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic clockEnable,
	input wire logic illegalDecode,
	input wire logic stopInstruction,
	input wire logic stopEnable,
	input wire logic opcodeFetch,
	input wire logic unmappedAddress,
	input wire logic serviceWrite,
	input wire logic lowVoltage,
	input wire logic resetPinOe,
	input wire logic internal_reset,
	input wire logic internal_bus_clocks,
	input wire logic gen_main_clock_out,
	input wire logic irqActive,
	input wire logic [$clog2(reset_seq_pkg::IRQ_SOURCES)-1:0] vectorSelect,
	input wire logic stackPush,
	input wire logic return_from_interrupt,
	input wire logic [7:0] reset_cause_register,
	input wire logic [reset_seq_pkg::PRESCALER_WIDTH-1:0] prescaler
);
	// Edges spent driving the pin, and edges of internal reset after it.
	logic [15:0] oeCount;
	logic [15:0] tailCount;
	// Sequencer is in normal running and may accept an event.
	wire logic calm = internal_bus_clocks && clockEnable && !lowVoltage;
	// ----------------------------------------
	// Span counters
	// ----------------------------------------
	// Counters restart whenever their phase ends, so a bad length shows at the fall.
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			oeCount <= 16'h0000;
			tailCount <= 16'h0000;
		end else if (clockEnable) begin
			oeCount <= resetPinOe ? oeCount + 16'h0001 : 16'h0000;
			tailCount <= (internal_reset && !resetPinOe) ? tailCount + 16'h0001 : 16'h0000;
		end
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	property p_pinSpan;
		$fell(resetPinOe) |-> oeCount == 16'h0020 || oeCount == 16'(STABILISE_CYCLES + 32);
	endproperty
	a_pinSpan: assert property (p_pinSpan) else $error("Pin drive span wrong.");
	property p_tail;
		$fell(internal_reset) |-> tailCount == 16'h0020;
	endproperty
	a_tail: assert property (p_tail) else $error("Reset tail span wrong.");
	property p_illegal;
		calm && illegalDecode |=> resetPinOe && internal_reset && reset_cause_register == 8'h10;
	endproperty
	a_illegal: assert property (p_illegal) else $error("Illegal decode missed.");
	property p_stopIllegal;
		calm && stopInstruction && !stopEnable |=> internal_reset && reset_cause_register == 8'h10;
	endproperty
	a_stopIllegal: assert property (p_stopIllegal) else $error("Stop not refused.");
	property p_fetch;
		calm && opcodeFetch && unmappedAddress && !illegalDecode && !stopInstruction
			|=> resetPinOe && reset_cause_register == 8'h08;
	endproperty
	a_fetch: assert property (p_fetch) else $error("Unmapped fetch missed.");
	property p_data;
		calm && unmappedAddress && !opcodeFetch && !illegalDecode && !stopInstruction
			|=> !resetPinOe;
	endproperty
	a_data: assert property (p_data) else $error("Data access reset.");
	property p_stop;
		calm && stopInstruction && stopEnable && !illegalDecode && !opcodeFetch
			|=> !gen_main_clock_out && prescaler == 13'h0000;
	endproperty
	a_stop: assert property (p_stop) else $error("Stop entry wrong.");
	property p_service;
		internal_bus_clocks && clockEnable && serviceWrite |=> prescaler[12:4] == 9'h000;
	endproperty
	a_service: assert property (p_service) else $error("Service clear missed.");
	property p_freeRun;
		internal_bus_clocks && $past(internal_bus_clocks) && $past(clockEnable)
			&& !$past(serviceWrite) |-> prescaler == $past(prescaler) + 13'h0001;
	endproperty
	a_freeRun: assert property (p_freeRun) else $error("Prescaler not running.");
	property p_porCause;
		$rose(rst_b) |-> reset_cause_register == 8'h80 && resetPinOe;
	endproperty
	a_porCause: assert property (p_porCause) else $error("Power-on cause wrong.");
	property p_clocksOff;
		internal_reset |-> !internal_bus_clocks && gen_main_clock_out;
	endproperty
	a_clocksOff: assert property (p_clocksOff) else $error("Clocks in reset wrong.");
	property p_irqHold;
		irqActive && !return_from_interrupt && clockEnable |=> irqActive && $stable(vectorSelect);
	endproperty
	a_irqHold: assert property (p_irqHold) else $error("Latched vector changed.");
	property p_push;
		$rose(irqActive) |-> ##[0:1] stackPush;
	endproperty
	a_push: assert property (p_push) else $error("Stack push missing.");
endmodule
bind reset_sequencer_and_prescaler reset_seq_sva #(.STABILISE_CYCLES(STABILISE_CYCLES)) i_sva (
	.clock, .rst_b, .clockEnable, .illegalDecode, .stopInstruction, .stopEnable,
	.opcodeFetch, .unmappedAddress, .serviceWrite, .lowVoltage, .resetPinOe,
	.internal_reset, .internal_bus_clocks, .gen_main_clock_out, .irqActive,
	.vectorSelect, .stackPush, .return_from_interrupt, .reset_cause_register, .prescaler
);

// *** reset_sequencer_and_prescaler_tb.sv ***
// Self-checking bench for the reset sequencer and prescaler.
`timescale 1ns/1ns
`define CHK(got, exp) begin \
	comparisons++; \
	if ((got) !== (exp)) begin \
		failures++; \
		$display("[ERR] %0t got %0h expected %0h", $time, got, exp); \
	end \
end
module reset_sequencer_and_prescaler_tb;
	localparam int STAB = 16;
	// Event row: {power_on_pulse, illegalDecode, stopInstruction,
	// stopEnable, opcodeFetch, unmappedAddress}.
	typedef struct packed {logic [5:0] ev; logic [7:0] cause; logic rst; logic [15:0] span;} row_t;
	row_t rows [5] = '{
		'{6'h14, 8'h10, 1'b1, 16'h0020}, '{6'h08, 8'h10, 1'b1, 16'h0020},
		'{6'h07, 8'h08, 1'b1, 16'h0020}, '{6'h05, 8'h08, 1'b0, 16'h0000},
		'{6'h24, 8'h80, 1'b1, 16'h0030}};
	logic clock = 0, rst_b = 0, clockEnable = 1, power_on_pulse = 0, lowVoltage = 0;
	logic illegalDecode = 0, stopInstruction = 0, opcodeFetch = 0, unmappedAddress = 0;
	logic serviceWrite = 0, wakeEvent = 0, stopEnable = 1, short_stop_recovery = 0;
	logic monitorMode = 0, breakState = 0, highVoltageResetPin = 0, highVoltageIrqPin = 0;
	logic irqStart = 0, return_from_interrupt = 0, holdLow = 0;
	logic [reset_seq_pkg::IRQ_SOURCES-1:0] irqRequest = 8'h00;
	logic resetPinIn, resetPinOut, resetPinOe, irqActive, stackPush, stackRestore;
	logic internal_reset, gen_main_clock_out, internal_bus_clocks, busClockEnable;
	logic [$clog2(reset_seq_pkg::IRQ_SOURCES)-1:0] vectorSelect;
	logic [7:0] reset_cause_register;
	logic [reset_seq_pkg::PRESCALER_WIDTH-1:0] prescaler, held;
	logic [15:0] lastLow;
	int failures = 0, comparisons = 0, n, shortN;
	// Clock at the reference rate.
	always #(reset_seq_pkg::CLOCK_PERIOD_NS / 2) clock = ~clock;
	reset_sequencer_and_prescaler #(.STABILISE_CYCLES(STAB), .LONG_RECOVERY(STAB),
		.WATCHDOG_BITS(2)) i_dut (
		.clock, .rst_b, .clockEnable, .power_on_pulse, .lowVoltage, .resetPinIn,
		.resetPinOut, .resetPinOe, .illegalDecode, .stopInstruction, .opcodeFetch,
		.unmappedAddress, .serviceWrite, .wakeEvent, .stopEnable, .short_stop_recovery,
		.monitorMode, .breakState, .highVoltageResetPin, .highVoltageIrqPin, .irqRequest,
		.irqStart, .return_from_interrupt, .irqActive, .vectorSelect, .stackPush,
		.stackRestore, .internal_reset, .gen_main_clock_out, .internal_bus_clocks,
		.busClockEnable, .reset_cause_register, .prescaler);
	// The peripheral on the shared reset line.
	reset_pin_partner i_peer (.clock, .resetPinOut, .resetPinOe, .holdLow,
		.pinLevel(resetPinIn), .lastLow);
	// Step k edges, then move just past the edge so outputs have settled.
	task automatic tick(input int k);
		repeat (k) @(posedge clock);
		#1;
	endtask
	// Wait, bounded, until normal running resumes; n holds the edges taken.
	task automatic waitRun();
		n = 0;
		while (internal_bus_clocks !== 1'b1 && n < 20000) begin
			tick(1);
			n++;
		end
	endtask
	// Print the counts and the verdict, then stop.
	task automatic wrap_up();
		$display("Mismatches %0d in %0d comparisons", failures, comparisons);
		if (failures == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// A hang is cut short well after the long watchdog waits.
	initial begin
		#(90_000 * reset_seq_pkg::CLOCK_PERIOD_NS);
		failures++;
		wrap_up();
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		tick(1);
		`CHK(resetPinOe, 1'b1)
		`CHK(internal_bus_clocks, 1'b0)
		`CHK(gen_main_clock_out, 1'b1)
		`CHK(reset_cause_register, 8'h80)
		tick(2);
		rst_b = 1;
		n = 0;
		while (internal_reset !== 1'b0 && n < 1000) begin
			tick(1);
			n++;
		end
		`CHK(n, STAB + 64)
		waitRun();
		`CHK(busClockEnable, 1'b1)
		// Table of one-cycle events: reset sources and a data access that must not reset.
		foreach (rows[i]) begin
			{power_on_pulse, illegalDecode, stopInstruction, stopEnable,
				opcodeFetch, unmappedAddress} = rows[i].ev;
			tick(1);
			{power_on_pulse, illegalDecode, stopInstruction, opcodeFetch, unmappedAddress} = 5'h00;
			stopEnable = 1;
			`CHK(resetPinOe, rows[i].rst)
			`CHK(reset_cause_register, rows[i].cause)
			waitRun();
			if (rows[i].rst) `CHK(lastLow, rows[i].span)
		end
		// Low-voltage reset holds the pin through the long count.
		lowVoltage = 1;
		tick(5);
		`CHK(resetPinOe, 1'b1)
		`CHK(reset_cause_register, 8'h02)
		lowVoltage = 0;
		waitRun();
		`CHK(lastLow, 16'(STAB + 32))
		// Stop entry and both recovery lengths.
		for (int s = 1; s >= 0; s--) begin
			stopInstruction = 1;
			tick(1);
			stopInstruction = 0;
			`CHK(gen_main_clock_out, 1'b0)
			`CHK(prescaler, 13'h0000)
			short_stop_recovery = s[0];
			wakeEvent = 1;
			tick(1);
			wakeEvent = 0;
			waitRun();
			if (s == 1) shortN = n;
		end
		`CHK(shortN, reset_seq_pkg::SHORT_RECOVERY_CYCLES)
		`CHK(n, STAB)
		// Pin held low too briefly, then long enough.
		foreach (rows[k]) if (k < 2) begin
			holdLow = 1;
			tick(k == 0 ? 40 : 70);
			holdLow = 0;
			tick(5);
			`CHK(reset_cause_register, k == 0 ? 8'h02 : 8'h40)
		end
		// Freezing the enable holds the prescaler.
		clockEnable = 0;
		held = prescaler;
		tick(5);
		`CHK(prescaler, held)
		clockEnable = 1;
		tick(300);
		serviceWrite = 1;
		tick(1);
		serviceWrite = 0;
		`CHK(prescaler[12:4], 9'h000)
		// Interrupt latch keeps its winner until return.
		irqRequest = 8'h24;
		irqStart = 1;
		tick(1);
		irqStart = 0;
		tick(2);
		`CHK(irqActive, 1'b1)
		`CHK(vectorSelect, 3'h2)
		irqRequest = 8'h01;
		irqStart = 1;
		tick(1);
		irqStart = 0;
		`CHK(vectorSelect, 3'h2)
		return_from_interrupt = 1;
		#1;
		`CHK(stackRestore, 1'b1)
		tick(1);
		return_from_interrupt = 0;
		irqRequest = 8'h00;
		tick(1);
		`CHK(irqActive, 1'b0)
		// Unserviced watchdog overflows and resets.
		n = 0;
		while (internal_reset !== 1'b1 && n < 40000) begin
			tick(1);
			n++;
		end
		`CHK(reset_cause_register, 8'h20)
		waitRun();
		// High voltage on the pin during break keeps the watchdog quiet.
		breakState = 1;
		highVoltageResetPin = 1;
		// Any edge spent in internal reset during the span is a missed disable.
		n = 0;
		repeat (40000) begin
			tick(1);
			if (internal_reset !== 1'b0) n++;
		end
		`CHK(n, 0)
		`CHK(internal_bus_clocks, 1'b1)
		`CHK(reset_cause_register, 8'h20)
		wrap_up();
	end
endmodule
